/* rtl/hcc_top.sv */
// Command and status registers of a host controller with one physical
// and one virtual function instance, reached over Avalon-MM.
// Assumes controller-side inputs are on clk; software keeps its own rules.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "hcc_regs.svh"

// Summary of operation
// R1: Writing one to soft reset restarts all internal state machines and counters.
// R2: Starting a soft reset aborts any USB transaction in progress at once.
// R3: Soft reset drives no USB2 bus reset but starts a USB3 port reset.
// R4: Soft reset leaves configuration space registers untouched.
// R5: Soft reset returns every operational register and port state to initial values.
// R6: Hardware clears the soft reset bit itself when the reset finishes.
// R7: Writing zero during a reset does nothing; the reset runs to the end.
// R8: Software must not write operational registers while soft reset reads one.
// R9: Reset completion never waits for a root hub port reset.
// R10: Software must not start a reset while the halted flag reads zero.
// R11: Software must fully reinitialise the controller after a reset.
// R12: Interrupter interrupts pass only while the interrupter gate enable is one.
// R13: Interrupts are acknowledged through the host mechanism, not the enable bit.
// R14: Error signal asserts while both error enable and error flag are one.
// R15: Software clears the error flag to acknowledge; the signal then drops.
// R16: A function's soft reset bit resets only that function's instance.
// R17: A function's interrupt gate governs only interrupters of that function.
// R18: A function's run bit governs only that function's run state.
// R19: Halted reads one only after pending work drains and the instance stops.
// R20: Reset, interrupt and error enable power up zero, each in its own bit.
module hcc_top
	import hcc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Avalon-MM slave
	input  wire logic [`HCC_ADDR_W-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [`HCC_DATA_W-1:0] avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic      [`HCC_DATA_W-1:0] avs_readdata,
	output logic                        avs_waitrequest,
	// Controller core, per instance
	input  wire hcc_fn_vec_t            fn_pipe_idle,
	input  wire hcc_fn_vec_t            fn_sys_error_event,
	input  wire hcc_fn_vec_t            fn_intr_req,
	input  wire hcc_fn_vec_t            fn_intr_mech_en,
	output hcc_fn_vec_t                 fn_run,
	output hcc_fn_vec_t                 fn_soft_reset,
	output hcc_fn_vec_t                 fn_abort_xfer,
	// Root hub ports, per instance
	output hcc_fn_vec_t                 fn_usb3_port_reset,
	output hcc_fn_vec_t                 fn_usb2_port_reset,
	// Gated host signalling, per instance
	output hcc_fn_vec_t                 fn_intr_out,
	output hcc_fn_vec_t                 fn_sys_error_out
);

	// ======================================================================
	// Bus handshake state
	logic                   wait_reg;
	logic [`HCC_DATA_W-1:0] rdata_reg;

	// Decode wires
	logic                   req;
	logic                   accept;
	logic                   commit_wr;
	logic                   addr_in_map;
	logic                   fn_sel;
	logic [`HCC_OFF_W-1:0]  reg_off;
	logic                   sel_cmd;
	logic                   sel_sts;
	logic                   lane0_wr;
	logic [`HCC_DATA_W-1:0] rd_data;

	// Per-instance register state
	hcc_fn_vec_t            run_reg;
	hcc_fn_vec_t            interrupter_gate_enable_reg;
	hcc_fn_vec_t            system_error_signal_enable_reg;
	hcc_fn_vec_t            hse_reg;
	hcc_fn_vec_t            halted_reg;

	// Per-instance decode and sequencer wires
	hcc_fn_vec_t            wr_cmd;
	hcc_fn_vec_t            wr_sts;
	hcc_fn_vec_t            rst_start;
	hcc_fn_vec_t            in_reset;
	hcc_fn_vec_t            abort_pulse;
	hcc_fn_vec_t            port_pulse;
	hcc_fn_vec_t            rst_done;
	hcc_fn_vec_t            usb2_rst_reg;

	// Per-instance read words
	logic [`HCC_DATA_W-1:0] cmd_word [`HCC_NUM_FN];
	logic [`HCC_DATA_W-1:0] sts_word [`HCC_NUM_FN];

	// ======================================================================
	// Address decode: bit 5 picks the instance, the low bits the register
	assign req         = avs_read | avs_write;
	assign addr_in_map = (avs_address[`HCC_ADDR_W-1:`HCC_FN_BIT+1] == '0);
	assign fn_sel      = avs_address[`HCC_FN_BIT];
	assign reg_off     = avs_address[`HCC_OFF_W-1:0];
	assign sel_cmd     = addr_in_map && (reg_off == `HCC_CMD_OFF);
	assign sel_sts     = addr_in_map && (reg_off == `HCC_STS_OFF);
	assign lane0_wr    = avs_write && avs_byteenable[0];

	// Request is taken on its first edge, while waitrequest is high; a write commits on the edge where waitrequest is seen low
	assign accept      = req && wait_reg;
	assign commit_wr   = lane0_wr && !wait_reg;

	// Read word of the addressed register; unmapped reads give zero
	assign rd_data = sel_cmd ? cmd_word[fn_sel] :
	                 sel_sts ? sts_word[fn_sel] : '0;

	// ======================================================================
	// One wait state: waitrequest drops for one cycle per request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg  <= 1'b1;
			rdata_reg <= '0;
		end else begin
			wait_reg <= !accept;
			if (accept) begin
				rdata_reg <= rd_data;
			end
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;

	// ======================================================================
	// Per-instance registers, sequencer and effects
	genvar f;
	generate
		for (f = 0; f < `HCC_NUM_FN; f = f + 1) begin : g_fn

			// Write strobes for this instance only
			assign wr_cmd[f] = commit_wr && sel_cmd && (fn_sel == 1'(f)); // R16
			assign wr_sts[f] = commit_wr && sel_sts && (fn_sel == 1'(f));

			// A one starts a reset; a zero is simply not a start
			assign rst_start[f] = wr_cmd[f] && avs_writedata[`HCC_CMD_RST_BIT]; // R1 R7

			hcc_reset_seq u_rst (
				.clk              (clk),
				.rst_n            (rst_n),
				.start            (rst_start[f]),
				.in_reset         (in_reset[f]),
				.abort_pulse      (abort_pulse[f]),
				.port_reset_pulse (port_pulse[f]),
				.done_pulse       (rst_done[f])
			);

			// Command fields; held at initial values through the reset
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					run_reg[f]  <= 1'b0; // R20
					interrupter_gate_enable_reg[f] <= 1'b0;
					system_error_signal_enable_reg[f] <= 1'b0;
				end else if (rst_start[f] || in_reset[f]) begin
					run_reg[f]  <= 1'b0; // R5
					interrupter_gate_enable_reg[f] <= 1'b0;
					system_error_signal_enable_reg[f] <= 1'b0;
				end else if (wr_cmd[f]) begin
					run_reg[f]  <= avs_writedata[`HCC_CMD_RUN_BIT]; // R18
					interrupter_gate_enable_reg[f] <= avs_writedata[`HCC_CMD_INTERRUPTER_GATE_ENABLE_BIT]; // R17
					system_error_signal_enable_reg[f] <= avs_writedata[`HCC_CMD_SYSTEM_ERROR_SIGNAL_ENABLE_BIT];
				end
			end

			// Error flag: event sets, write of one clears, set wins
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					hse_reg[f] <= 1'b0;
				end else if (rst_start[f] || in_reset[f]) begin
					hse_reg[f] <= 1'b0; // R5
				end else if (fn_sys_error_event[f]) begin
					hse_reg[f] <= 1'b1;
				end else if (wr_sts[f] && avs_writedata[`HCC_STS_HSE_BIT]) begin
					hse_reg[f] <= 1'b0; // R15
				end
			end

			// Halted once stopped and the pipeline has drained
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					halted_reg[f] <= `HCC_HALT_RESET;
				end else if (rst_start[f] || in_reset[f]) begin
					halted_reg[f] <= `HCC_HALT_RESET;
				end else begin
					halted_reg[f] <= !run_reg[f] && fn_pipe_idle[f]; // R19
				end
			end

			// USB2 ports never see a bus reset from soft reset
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					usb2_rst_reg[f] <= 1'b0;
				end else begin
					usb2_rst_reg[f] <= 1'b0; // R3
				end
			end

			// Read words; reserved bits read zero
			always_comb begin
				cmd_word[f] = `HCC_CMD_RESET;
				cmd_word[f][`HCC_CMD_RUN_BIT]  = run_reg[f];
				cmd_word[f][`HCC_CMD_RST_BIT]  = in_reset[f]; // R6
				cmd_word[f][`HCC_CMD_INTERRUPTER_GATE_ENABLE_BIT] = interrupter_gate_enable_reg[f];
				cmd_word[f][`HCC_CMD_SYSTEM_ERROR_SIGNAL_ENABLE_BIT] = system_error_signal_enable_reg[f];
			end

			always_comb begin
				sts_word[f] = '0;
				sts_word[f][`HCC_STS_HALT_BIT] = halted_reg[f];
				sts_word[f][`HCC_STS_HSE_BIT]  = hse_reg[f];
			end
		end
	endgenerate

	// ======================================================================
	// Core and port controls; configuration space is outside this block
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fn_run             <= '0;
			fn_soft_reset      <= '0;
			fn_abort_xfer      <= '0;
			fn_usb3_port_reset <= '0;
		end else begin
			fn_run             <= run_reg & ~in_reset; // R18
			fn_soft_reset      <= in_reset; // R1 R4 R5
			fn_abort_xfer      <= abort_pulse; // R2
			fn_usb3_port_reset <= port_pulse; // R3 R9
		end
	end

	assign fn_usb2_port_reset = usb2_rst_reg;

	// ======================================================================
	// Interrupt and error gating
	hcc_out_gate u_gate (
		.clk          (clk),
		.rst_n        (rst_n),
		.intr_req     (fn_intr_req),
		.intr_mech_en (fn_intr_mech_en),
		.interrupter_gate_enable         (interrupter_gate_enable_reg),
		.system_error_flag          (hse_reg),
		.system_error_signal_enable         (system_error_signal_enable_reg),
		.in_reset     (in_reset),
		.intr_out     (fn_intr_out),
		.sys_err_out  (fn_sys_error_out)
	);

endmodule

/* rtl/hcc_regs.svh */
// Constants of the host controller command and status block: offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HCC_REGS_SVH
`define HCC_REGS_SVH

// ==========================================================================
// Bus geometry
`define HCC_ADDR_W        8
`define HCC_DATA_W        32
`define HCC_NUM_FN        2
// Address bit that selects the function instance (0 physical, 1 virtual)
`define HCC_FN_BIT        5
`define HCC_OFF_W         5
`define HCC_CMD_OFF       5'h00
`define HCC_STS_OFF       5'h04

// ==========================================================================
// host_command fields
`define HCC_CMD_RUN_BIT   0
`define HCC_CMD_RST_BIT   1
`define HCC_CMD_INTERRUPTER_GATE_ENABLE_BIT  2
`define HCC_CMD_SYSTEM_ERROR_SIGNAL_ENABLE_BIT  3

// host_status fields
`define HCC_STS_HALT_BIT  0
`define HCC_STS_HSE_BIT   2

// Reset values
`define HCC_CMD_RESET     32'h0000_0000
`define HCC_HALT_RESET    1'b1

// ==========================================================================
// Timing: soft reset hold time and its cycle count at 40 MHz (round up)
`define HCC_CLK_PERIOD_NS 25
`define HCC_RST_TIME_NS   1000
`define HCC_CNT_W         16
`define HCC_RST_CYCLES    ((`HCC_RST_TIME_NS + `HCC_CLK_PERIOD_NS - 1) / `HCC_CLK_PERIOD_NS)

`endif

/* rtl/hcc_pkg.sv */
// Types shared by the host controller command block.
// Assumes the constants header is on the include path.
`include "hcc_regs.svh"

package hcc_pkg;

	// ======================================================================
	// Soft reset sequencer states, one-hot
	typedef enum logic [2:0] {
		HCC_RST_IDLE  = 3'b001,
		HCC_RST_ABORT = 3'b010,
		HCC_RST_HOLD  = 3'b100
	} hcc_rst_state_e;

	typedef logic [`HCC_NUM_FN-1:0] hcc_fn_vec_t;

endpackage

/* rtl/hcc_reset_seq.sv */
// Soft reset sequencer for one controller instance.
// Assumes start comes from same-clock register logic.
`timescale 1ns/1ps
`include "hcc_regs.svh"

module hcc_reset_seq
	import hcc_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control
	input  wire logic start,
	// Status and effects
	output logic      in_reset,
	output logic      abort_pulse,
	output logic      port_reset_pulse,
	output logic      done_pulse
);

	localparam logic [`HCC_CNT_W-1:0] HOLD_LAST = `HCC_CNT_W'(`HCC_RST_CYCLES - 1);

	hcc_rst_state_e         state_reg;
	hcc_rst_state_e         state_next;
	logic [`HCC_CNT_W-1:0]  cnt_reg;
	logic [`HCC_CNT_W-1:0]  cnt_next;
	logic                   hold_end;

	// ======================================================================
	// Next state; a start while busy is ignored so the reset runs out
	assign hold_end = (cnt_reg == HOLD_LAST);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			HCC_RST_IDLE: begin
				if (start) begin
					state_next = HCC_RST_ABORT; // R1
				end
			end
			HCC_RST_ABORT: begin
				state_next = HCC_RST_HOLD;
				cnt_next   = '0;
			end
			HCC_RST_HOLD: begin
				// Completion does not wait on any port reset
				if (hold_end) begin
					state_next = HCC_RST_IDLE; // R9
				end else begin
					cnt_next = cnt_reg + `HCC_CNT_W'(1);
				end
			end
			default: begin
				state_next = HCC_RST_IDLE;
			end
		endcase
	end

	// ======================================================================
	// State and registered outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg        <= HCC_RST_IDLE;
			cnt_reg          <= '0;
			in_reset         <= 1'b0;
			abort_pulse      <= 1'b0;
			port_reset_pulse <= 1'b0;
			done_pulse       <= 1'b0;
		end else begin
			state_reg        <= state_next;
			cnt_reg          <= cnt_next;
			in_reset         <= (state_next != HCC_RST_IDLE); // R6 R7
			abort_pulse      <= (state_next == HCC_RST_ABORT); // R2
			port_reset_pulse <= (state_next == HCC_RST_ABORT); // R3
			done_pulse       <= (state_reg == HCC_RST_HOLD) && hold_end;
		end
	end

endmodule

/* rtl/hcc_out_gate.sv */
// Gating of interrupter interrupts and out-of-band error signalling,
// one lane per controller instance.
// Assumes all inputs come from same-clock logic.
`timescale 1ns/1ps
`include "hcc_regs.svh"

module hcc_out_gate
	import hcc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Interrupter side
	input  wire hcc_fn_vec_t intr_req,
	input  wire hcc_fn_vec_t intr_mech_en,
	input  wire hcc_fn_vec_t interrupter_gate_enable,
	// Error side, and the reset state that gates interrupts
	input  wire hcc_fn_vec_t system_error_flag,
	input  wire hcc_fn_vec_t system_error_signal_enable,
	input  wire hcc_fn_vec_t in_reset,
	// Gated outputs
	output hcc_fn_vec_t      intr_out,
	output hcc_fn_vec_t      sys_err_out
);

	hcc_fn_vec_t intr_next;
	hcc_fn_vec_t err_next;

	// ======================================================================
	// Each instance gates only its own interrupters
	assign intr_next = intr_req & intr_mech_en & interrupter_gate_enable & ~in_reset; // R12 R17
	// Error signal follows the flag, so clearing the flag drops it
	assign err_next  = system_error_flag & system_error_signal_enable; // R14 R15

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intr_out    <= '0;
			sys_err_out <= '0;
		end else begin
			intr_out    <= intr_next;
			sys_err_out <= err_next;
		end
	end

endmodule

/* tb/hcc_top_sva.sv */
// Port checker for the command block.
// Assumes it is bound to hcc_top and sees one clock domain.
`timescale 1ns/1ps

module hcc_top_sva
	import hcc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Bus handshake
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	// Controller side
	input wire hcc_fn_vec_t fn_intr_req,
	input wire hcc_fn_vec_t fn_intr_mech_en,
	input wire hcc_fn_vec_t fn_run,
	input wire hcc_fn_vec_t fn_soft_reset,
	input wire hcc_fn_vec_t fn_abort_xfer,
	input wire hcc_fn_vec_t fn_usb3_port_reset,
	input wire hcc_fn_vec_t fn_usb2_port_reset,
	input wire hcc_fn_vec_t fn_intr_out
);
	logic [7:0] len_reg;

	// ==========
	// Helper: length of the soft reset on lane 1, the lane the bench resets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			len_reg <= 8'h00;
		else
			len_reg <= fn_soft_reset[1] ? len_reg + 8'h01 : 8'h00;
	end

	// ==========
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_port_with_abort:
		assert property (fn_abort_xfer == fn_usb3_port_reset) else $error("port reset off abort");
	a_no_usb2_reset:
		assert property (fn_usb2_port_reset == 2'h0) else $error("usb2 bus reset driven");
	a_abort_at_start:
		assert property (|fn_abort_xfer |->
			(fn_abort_xfer & ~(fn_soft_reset & ~$past(fn_soft_reset))) == 2'h0)
			else $error("abort outside reset start");
	a_reset_length:
		assert property ($fell(fn_soft_reset[1]) |-> len_reg == 8'h29)
			else $error("soft reset length wrong");
	a_run_in_reset:
		assert property ((fn_run & fn_soft_reset) == 2'h0) else $error("run during reset");
	a_intr_cause:
		assert property (|fn_intr_out |->
			(fn_intr_out & ~($past(fn_intr_req) & $past(fn_intr_mech_en))) == 2'h0)
			else $error("interrupt without cause");
	a_intr_quiet:
		assert property ((fn_intr_out & fn_soft_reset) == 2'h0) else $error("interrupt in reset");
	a_wait_one:
		assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
			else $error("answer late");
	a_wait_single:
		assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
endmodule

bind hcc_top hcc_top_sva u_sva (
	.clk                (clk),
	.rst_n              (rst_n),
	.avs_read           (avs_read),
	.avs_write          (avs_write),
	.avs_waitrequest    (avs_waitrequest),
	.fn_intr_req        (fn_intr_req),
	.fn_intr_mech_en    (fn_intr_mech_en),
	.fn_run             (fn_run),
	.fn_soft_reset      (fn_soft_reset),
	.fn_abort_xfer      (fn_abort_xfer),
	.fn_usb3_port_reset (fn_usb3_port_reset),
	.fn_usb2_port_reset (fn_usb2_port_reset),
	.fn_intr_out        (fn_intr_out)
);

/* tb/hcc_core_model.sv */
// Model of the controller core behind the command block.
// Assumes bench commands change right after a rising edge.
`timescale 1ns/1ps

module hcc_core_model
	import hcc_pkg::*;
#(
	parameter int DRAIN = 8
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Bench commands
	input  wire hcc_fn_vec_t irq_cmd,
	input  wire hcc_fn_vec_t err_cmd,
	input  wire hcc_fn_vec_t mech_cmd,
	// From the block
	input  wire hcc_fn_vec_t fn_run,
	// To the block
	output hcc_fn_vec_t      fn_pipe_idle,
	output hcc_fn_vec_t      fn_sys_error_event,
	output hcc_fn_vec_t      fn_intr_req,
	output hcc_fn_vec_t      fn_intr_mech_en
);
	int left [2];

	// Pipeline drains slowly after a lane stops; events are one-cycle pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left <= '{0, 0};
			fn_intr_req <= 2'h0;
			fn_sys_error_event <= 2'h0;
		end else begin
			for (int f = 0; f < 2; f++)
				left[f] <= fn_run[f] ? DRAIN : (left[f] > 0 ? left[f] - 1 : 0);
			fn_intr_req <= irq_cmd;
			fn_sys_error_event <= err_cmd;
		end
	end

	// Idle only when stopped and drained; acknowledge stays with host mechanism
	assign fn_pipe_idle = {left[1] == 0 && !fn_run[1], left[0] == 0 && !fn_run[0]};
	assign fn_intr_mech_en = mech_cmd;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the command block.
// Assumes the checker is bound and the core model stands behind the block.
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))

module testbench
	import hcc_pkg::*;
;
	logic        clk, rst_n, rd_r, wr_r, wait_w;
	logic [7:0]  addr;
	logic [31:0] wdat, rdat, q;
	logic [15:0] seed;
	hcc_fn_vec_t idle, ev, irq, mech, run, srst, abrt, p3, p2, iout, eout;
	hcc_fn_vec_t irq_cmd, err_cmd, mech_cmd, er, sa, sp, s2, si;
	int          fails, n_checks, rlen, rlast, i;

	// ==========
	// Design and core model
	hcc_top dut (.clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd_r),
		.avs_write(wr_r), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
		.avs_waitrequest(wait_w), .fn_pipe_idle(idle), .fn_sys_error_event(ev),
		.fn_intr_req(irq), .fn_intr_mech_en(mech), .fn_run(run), .fn_soft_reset(srst),
		.fn_abort_xfer(abrt), .fn_usb3_port_reset(p3), .fn_usb2_port_reset(p2),
		.fn_intr_out(iout), .fn_sys_error_out(eout));
	hcc_core_model #(.DRAIN(8)) u_core (.clk(clk), .rst_n(rst_n), .irq_cmd(irq_cmd),
		.err_cmd(err_cmd), .mech_cmd(mech_cmd), .fn_run(run), .fn_pipe_idle(idle),
		.fn_sys_error_event(ev), .fn_intr_req(irq), .fn_intr_mech_en(mech));

	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Monitors: sticky pulse capture and soft reset length on lane 1
	always @(negedge clk) begin
		sa = sa | abrt;
		sp = sp | p3;
		s2 = s2 | p2;
		si = si | iout;
	end
	always @(posedge clk) begin
		rlen <= srst[1] ? rlen + 1 : 0;
		if (!srst[1] && rlen != 0)
			rlast <= rlen;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] exp_cmd(input logic [15:0] s);
		return {16'h0000, s} & 32'h0000_000d;
	endfunction

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		wr_r <= wr;
		rd_r <= !wr;
		addr <= a;
		wdat <= d;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (wait_w === 1'b0)
				break;
		end
		if (k == 16) begin
			fails++;
			close_out();
		end
		q = rdat;
		wr_r <= 1'b0;
		rd_r <= 1'b0;
	endtask

	// One-cycle command to the core model: error event if err, else interrupt
	task automatic pulse(input bit err);
		@(posedge clk);
		if (err) begin
			err_cmd <= 2'h3;
		end else begin
			irq_cmd <= 2'h3;
		end
		@(posedge clk);
		irq_cmd <= 2'h0;
		err_cmd <= 2'h0;
		repeat (4) @(negedge clk);
	endtask

	// Main sequence
	initial begin
		{rst_n, rd_r, wr_r, addr, wdat, irq_cmd, err_cmd, mech_cmd} = '0;
		{sa, sp, s2, si, er, fails, n_checks, rlen, rlast} = '0;
		seed = 16'h0035;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, 8'h00, 0);
		`CHK(q, 0);
		bus(0, 8'h24, 0);
		`CHK(q, 1);
		bus(1, 8'h08, 32'hffff_ffff);
		bus(0, 8'h08, 0);
		`CHK(q, 0);
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			er[seed[5]] = seed[0];
			bus(1, {2'b00, seed[5], 5'h00}, 32'(seed) & 32'hffff_fffd);
			repeat (2) @(negedge clk);
			`CHK(run, er);
			bus(0, {2'b00, seed[5], 5'h00}, 0);
			`CHK(q, exp_cmd(seed));
		end
		bus(1, 8'h00, 32'h5);
		bus(1, 8'h20, 32'h1);
		mech_cmd <= 2'h3;
		si = 2'h0;
		pulse(1'b0);
		`CHK(si, 2'h1);
		bus(1, 8'h20, 32'h5);
		mech_cmd <= 2'h2;
		si = 2'h0;
		pulse(1'b0);
		`CHK(si, 2'h2);
		bus(1, 8'h00, 32'h8);
		bus(0, 8'h04, 0);
		`CHK(q, 0);
		repeat (12) @(posedge clk);
		pulse(1'b1);
		`CHK(eout, 2'h1);
		bus(0, 8'h04, 0);
		`CHK(q, 32'h5);
		bus(1, 8'h04, 32'h4);
		repeat (3) @(negedge clk);
		`CHK(eout, 2'h0);
		bus(0, 8'h04, 0);
		`CHK(q, 32'h1);
		bus(1, 8'h20, 32'h4);
		bus(1, 8'h00, 32'h9);
		repeat (12) @(posedge clk);
		{sa, sp, si} = '0;
		bus(1, 8'h20, 32'h6);
		bus(0, 8'h20, 0);
		`CHK(q, 32'h2);
		bus(1, 8'h20, 32'h0);
		for (i = 0; i < 80; i++) begin
			bus(0, 8'h20, 0);
			if (q[1] === 1'b0)
				break;
		end
		if (i == 80)
			fails++;
		repeat (3) @(posedge clk);
		`CHK(rlast, 41);
		`CHK(sa, 2'h2);
		`CHK(sp, 2'h2);
		`CHK(s2, 2'h0);
		`CHK(run, 2'h1);
		`CHK(q, 0);
		bus(0, 8'h24, 0);
		`CHK(q, 1);
		bus(0, 8'h00, 0);
		`CHK(q, 32'h9);
		bus(1, 8'h20, 32'h4);
		bus(0, 8'h20, 0);
		`CHK(q, 32'h4);
		close_out();
	end
endmodule
